// *** inc/rprs_pkg.sv ***
// ***************************************************
// timing constants shared by both ends
// ***************************************************
package rprs_pkg;
   localparam int unsigned MCLK_HZ = 32'h02FAF080;
   localparam int unsigned MS_PER_S = 32'h000003E8;
   localparam int unsigned US_PER_MS = 32'h000003E8;
   localparam int unsigned CYC_PER_MS = MCLK_HZ / MS_PER_S;
   localparam int unsigned DIV_W = 32'h00000010;
   localparam int unsigned MS_W = 32'h00000011;

   // device side thresholds, in ms or s
   localparam logic [MS_W-1:0] RESET_MIN_MS = 17'h00032;
   localparam logic [MS_W-1:0] POWER_DOWN_MS = 17'h003E8;
   localparam int unsigned RESTART_S = 32'h0000003C;
   localparam logic [MS_W-1:0] RESTART_MS = MS_W'(RESTART_S * MS_PER_S);
   localparam logic [MS_W-1:0] RADIO_RST_MS = 17'h0000A;

   // host side timing, in ms, s or us
   localparam int unsigned SHUTDOWN_WAIT_S = 32'h0000001E;
   localparam logic [MS_W-1:0] SHUTDOWN_WAIT_MS = MS_W'(SHUTDOWN_WAIT_S * MS_PER_S);
   localparam logic [MS_W-1:0] HOST_RST_LOW_MS = 17'h000C8;
   localparam logic [MS_W-1:0] HOST_OFF_LOW_MS = 17'h005DC;
   localparam int unsigned CPU_RST_MIN_US = 32'h000000C8;
   localparam logic [MS_W-1:0] CPU_RST_MS =
      MS_W'((CPU_RST_MIN_US + US_PER_MS - 1) / US_PER_MS);
endpackage

// *** inc/rprs_link_if.sv ***
// ***************************************************
// wires between the host and the supervisor
// ***************************************************
interface rprs_link_if;
   logic radio_power_ctl_n;
   logic radio_rail_monitor;
   logic board_reset_n;
   logic cpu_reset_input_n;
   logic radio_shutdown_command;

   modport dev (
      input radio_power_ctl_n,
      input board_reset_n,
      input radio_shutdown_command,
      output radio_rail_monitor,
      output cpu_reset_input_n
   );

   modport host (
      output radio_power_ctl_n,
      output board_reset_n,
      output radio_shutdown_command,
      input radio_rail_monitor,
      input cpu_reset_input_n
   );
endinterface

// *** logic/rprs_host.sv ***
// ***************************************************
// host end: drives the power-control line
// ***************************************************
module rprs_host #(
   parameter int unsigned MS_CYCLES = rprs_pkg::CYC_PER_MS
) (
   input wire logic mclk,
   input wire logic rst,
   rprs_link_if.host link,
   input wire logic req_radio_reset,
   input wire logic req_power_down,
   input wire logic req_shutdown,
   input wire logic req_wake,
   input wire logic req_cpu_reset,
   output logic busy,
   output logic safe_to_remove,
   output logic cpu_in_reset
);
   typedef enum {
      H_IDLE, H_RST_LOW, H_OFF_LOW, H_MON_WAIT, H_SHDN_WAIT, H_SAFE, H_CPU_RST
   } rprs_host_state_t;

   rprs_host_state_t state;
   rprs_host_state_t next_state;
   logic [rprs_pkg::DIV_W-1:0] div_cnt;
   logic [rprs_pkg::MS_W-1:0] ms_cnt;
   logic [1:0] in_meta;
   logic [1:0] in_sync;
   logic ctl_n;
   logic brst_n;
   logic shdn;
   wire tick = div_cnt == rprs_pkg::DIV_W'(MS_CYCLES - 1);
   wire restart = next_state != state;
   wire mon_sync = in_sync[0];
   wire line_low = next_state == H_RST_LOW || next_state == H_OFF_LOW ||
      next_state == H_MON_WAIT || next_state == H_SAFE;

   assign link.radio_power_ctl_n = ctl_n;
   assign link.board_reset_n = brst_n;
   assign link.radio_shutdown_command = shdn;

   // ***************************************************
   // input synchronisers and millisecond timer
   // ***************************************************
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         in_meta <= 2'h3;
         in_sync <= 2'h3;
      end else begin
         in_meta <= {link.cpu_reset_input_n, link.radio_rail_monitor};
         in_sync <= in_meta;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
         ms_cnt <= '0;
      end else if (restart) begin
         div_cnt <= '0;
         ms_cnt <= '0;
      end else if (tick) begin
         div_cnt <= '0;
         ms_cnt <= ms_cnt + 17'h00001;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // ***************************************************
   // sequencing
   // ***************************************************
   always_comb begin
      next_state = state;
      case (state)
         H_IDLE: begin
            if (req_cpu_reset) next_state = H_CPU_RST;
            else if (req_radio_reset) next_state = H_RST_LOW;
            else if (req_power_down) next_state = H_OFF_LOW;
            else if (req_shutdown) next_state = H_SHDN_WAIT;
         end
         H_RST_LOW: begin
            if (ms_cnt >= rprs_pkg::HOST_RST_LOW_MS) next_state = H_IDLE;
         end
         H_OFF_LOW: begin
            if (ms_cnt >= rprs_pkg::HOST_OFF_LOW_MS) next_state = H_MON_WAIT;
         end
         H_MON_WAIT: begin
            if (!mon_sync) next_state = H_SAFE;
         end
         H_SHDN_WAIT: begin
            if (ms_cnt >= rprs_pkg::SHUTDOWN_WAIT_MS) next_state = H_SAFE;
         end
         H_SAFE: begin
            if (req_wake) next_state = H_IDLE;
         end
         H_CPU_RST: begin
            if (ms_cnt >= rprs_pkg::CPU_RST_MS) next_state = H_IDLE;
         end
         default: next_state = H_IDLE;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= H_IDLE;
         ctl_n <= 1'h1;
         brst_n <= 1'h1;
         shdn <= 1'h0;
         busy <= 1'h0;
         safe_to_remove <= 1'h0;
         cpu_in_reset <= 1'h0;
      end else begin
         state <= next_state;
         ctl_n <= !line_low;
         brst_n <= next_state != H_CPU_RST;
         shdn <= state == H_IDLE && next_state == H_SHDN_WAIT;
         busy <= next_state != H_IDLE && next_state != H_SAFE;
         safe_to_remove <= next_state == H_SAFE;
         cpu_in_reset <= !in_sync[1];
      end
   end
endmodule // rprs_host

// *** logic/rprs_supervisor.sv ***
// ***************************************************
// radio supervisor: classifies low time on the
// power-control line and sequences the radio
// ***************************************************

// How it works
// - low over 50 ms up to 1 s resets radio
// - low over 1 s powers radio down
// - line held low keeps radio off
// - line high resets and wakes radio
// - rail monitor low once radio off
// - host waits 30 s after shutdown command
// - shutdown with line high restarts after 60 s
// - cpu reset pulse 200 us to 1 s
// - board reset passes straight to cpu
// - host toggles line to leave sleep
module rprs_supervisor #(
   parameter int unsigned MS_CYCLES = rprs_pkg::CYC_PER_MS
) (
   input wire logic mclk,
   input wire logic rst,
   rprs_link_if.dev link,
   output logic radio_power_en,
   output logic radio_reset,
   output logic radio_awake
);
   typedef enum {
      S_WAKE,
      S_ON,
      S_LOW,
      S_OFF,
      S_SHDN
   } rprs_dev_state_t;

   rprs_dev_state_t state;
   rprs_dev_state_t next_state;
   logic [rprs_pkg::DIV_W-1:0] div_cnt;
   logic [rprs_pkg::MS_W-1:0] ms_cnt;
   logic ctl_meta;
   logic ctl_sync;
   logic monitor;

   // ***************************************************
   // decoding
   // ***************************************************
   // divider restarts with each state so a hold time is
   // measured from the edge that opened it
   wire tick = div_cnt == rprs_pkg::DIV_W'(MS_CYCLES - 1);
   wire restart = next_state != state;
   wire ms_full = &ms_cnt;
   wire line_high = ctl_sync;
   wire line_low = !ctl_sync;
   wire short_low = ms_cnt <= rprs_pkg::RESET_MIN_MS;
   wire long_low = ms_cnt > rprs_pkg::POWER_DOWN_MS;
   wire restart_due = ms_cnt >= rprs_pkg::RESTART_MS;
   wire wake_done = ms_cnt >= rprs_pkg::RADIO_RST_MS;
   wire shdn_cmd = link.radio_shutdown_command;
   wire rail_up = next_state != S_OFF && next_state != S_SHDN;

   // output decode, one cycle ahead of the flops
   wire hold_reset = next_state == S_WAKE;
   wire running = next_state == S_ON || next_state == S_LOW;
   // a shutdown pulse outside S_ON is dropped, so the host
   // has to wait until the radio runs before sending it
   wire shdn_taken = shdn_cmd && state == S_ON;

   assign link.radio_rail_monitor = monitor;

   assign link.cpu_reset_input_n = link.board_reset_n;

   // ***************************************************
   // line synchroniser
   // ***************************************************
   // the line comes from another chip; idle level is high
   // two flops cost 40 ns, nothing beside a 50 ms threshold
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctl_meta <= 1'h1;
         ctl_sync <= 1'h1;
      end else begin
         ctl_meta <= link.radio_power_ctl_n;
         ctl_sync <= ctl_meta;
      end
   end

   // ***************************************************
   // millisecond timer
   // ***************************************************
   // counts whole ms since state entry and saturates, so a
   // line parked low for hours never wraps into a short low
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         div_cnt <= '0;
      end else if (restart || tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ms_cnt <= '0;
      end else if (restart) begin
         ms_cnt <= '0;
      end else if (tick && !ms_full) begin
         ms_cnt <= ms_cnt + 17'h00001;
      end
   end

   // ***************************************************
   // sequencer
   // ***************************************************
   always_comb begin
      next_state = state;
      case (state)
         S_WAKE: begin
            if (wake_done) begin
               next_state = S_ON;
            end
         end
         S_ON: begin
            if (shdn_taken) begin
               next_state = S_SHDN;
            end else if (line_low) begin
               next_state = S_LOW;
            end
         end
         S_LOW: begin
            if (line_high) begin
               if (short_low) begin
                  next_state = S_ON;
               end else begin
                  next_state = S_WAKE;
               end
            end else if (long_low) begin
               next_state = S_OFF;
            end
         end
         S_OFF: begin
            if (line_high) begin
               next_state = S_WAKE;
            end
         end
         S_SHDN: begin
            if (line_low) begin
               next_state = S_OFF;
            end else if (restart_due) begin
               next_state = S_WAKE;
            end
         end
         // an illegal state restarts the radio cleanly
         default: begin
            next_state = S_WAKE;
         end
      endcase
   end

   // ***************************************************
   // state and outputs
   // ***************************************************
   // outputs are taken from next_state so they line up with
   // the state register rather than trailing it by a cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state <= S_WAKE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         radio_power_en <= 1'h0;
         radio_reset <= 1'h1;
         radio_awake <= 1'h0;
      end else begin
         radio_power_en <= rail_up;
         radio_reset <= hold_reset;
         radio_awake <= running;
      end
   end

   // the monitor follows the rail one cycle late, so on power-down the host
   // never sees it low while the enable is still high
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         monitor <= 1'h0;
      end else begin
         monitor <= radio_power_en;
      end
   end
endmodule // rprs_supervisor

// *** verification/rprs_monitor.sv ***
// ****************************************
// link checker
// ****************************************
module rprs_monitor #(
   parameter int unsigned MS_CYCLES = rprs_pkg::CYC_PER_MS
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic radio_power_ctl_n,
   input wire logic radio_rail_monitor,
   input wire logic board_reset_n,
   input wire logic cpu_reset_input_n,
   input wire logic radio_shutdown_command
);
   timeunit 1ns;
   timeprecision 1ns;
   // slack of three ms and sync flops, since timing counts whole ms
   localparam int LOW_OFF = (int'(rprs_pkg::POWER_DOWN_MS) + 3) * int'(MS_CYCLES) + 8;
   localparam int LOW_MIN = int'(rprs_pkg::POWER_DOWN_MS) * int'(MS_CYCLES);
   int low_cnt;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // saturates so a parked low line cannot wrap
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         low_cnt <= 0;
      end else if (radio_power_ctl_n) begin
         low_cnt <= 0;
      end else if (low_cnt < LOW_OFF) begin
         low_cnt <= low_cnt + 1;
      end
   end

   a_cpu_reset_follow: assert property (cpu_reset_input_n == board_reset_n)
      else $error("cpu reset differs from board reset");
   a_long_low_off: assert property (low_cnt >= LOW_OFF |-> !radio_rail_monitor)
      else $error("rail still up after long low");
   a_short_low_kept: assert property ($fell(radio_rail_monitor) && !radio_power_ctl_n
      |-> low_cnt >= LOW_MIN) else $error("rail dropped on a short low");
   a_off_while_low: assert property ((!radio_power_ctl_n && !radio_rail_monitor)
      ##1 !radio_power_ctl_n |-> !radio_rail_monitor) else $error("rail rose while line low");
   a_rise_wakes: assert property ($rose(radio_power_ctl_n) && !radio_rail_monitor
      |-> ##[1:8] radio_rail_monitor) else $error("no wake after line rose");
   a_shdn_rail_low: assert property (radio_shutdown_command && radio_rail_monitor
      |-> ##[2:3] !radio_rail_monitor) else $error("rail up after shutdown");
   a_shdn_line_high: assert property (radio_shutdown_command
      |=> radio_power_ctl_n [*8]) else $error("line dropped after shutdown");
   a_cpu_pulse_min: assert property ($fell(board_reset_n) |-> !board_reset_n [*8])
      else $error("board reset pulse too short");
endmodule // rprs_monitor

// *** verification/tb_radio_power_reset_supervisor.sv ***
// ****************************************
// bench for host and supervisor
// ****************************************
module tb_radio_power_reset_supervisor;
   timeunit 1ns;
   timeprecision 1ns;
   // short ms keeps the 1.5 s power-down inside the cycle budget
   localparam int unsigned MSC = 10;
   typedef struct {logic [4:0] req; int ms; logic [3:0] exp;} rprs_row_t;
   logic mclk, rst, busy, safe, cpu_in, en, rr, awake;
   logic [4:0] req;
   int n_errors, n_compared, cyc;
   rprs_row_t rows [4];

   rprs_link_if rprs_link_if_inst ();
   wire line_n = rprs_link_if_inst.radio_power_ctl_n;
   wire rail = rprs_link_if_inst.radio_rail_monitor;
   wire brst_n = rprs_link_if_inst.board_reset_n;
   wire crst_n = rprs_link_if_inst.cpu_reset_input_n;
   rprs_supervisor #(.MS_CYCLES(MSC)) rprs_supervisor_inst (.mclk(mclk), .rst(rst),
      .link(rprs_link_if_inst), .radio_power_en(en), .radio_reset(rr), .radio_awake(awake));
   rprs_host #(.MS_CYCLES(MSC)) rprs_host_inst (.mclk(mclk), .rst(rst),
      .link(rprs_link_if_inst), .req_cpu_reset(req[4]), .req_radio_reset(req[3]),
      .req_power_down(req[2]), .req_shutdown(req[1]), .req_wake(req[0]), .busy(busy),
      .safe_to_remove(safe), .cpu_in_reset(cpu_in));
   rprs_monitor #(.MS_CYCLES(MSC)) rprs_monitor_inst (.mclk(mclk), .rst(rst),
      .radio_power_ctl_n(rprs_link_if_inst.radio_power_ctl_n),
      .radio_rail_monitor(rprs_link_if_inst.radio_rail_monitor),
      .board_reset_n(rprs_link_if_inst.board_reset_n),
      .cpu_reset_input_n(rprs_link_if_inst.cpu_reset_input_n),
      .radio_shutdown_command(rprs_link_if_inst.radio_shutdown_command));

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   task automatic pulse(input logic [4:0] r);
      @(posedge mclk);
      req <= r;
      @(posedge mclk);
      req <= 5'h00;
      #1;
   endtask

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end

   // a hang counts as a mismatch
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      rst = 1'h1;
      req = 5'h00;
      n_errors = 0;
      n_compared = 0;
      cyc = 0;
      // rows: request, settle ms, {power, rail, safe, awake}
      rows = '{'{5'h10, 0, 4'hD}, '{5'h08, 1, 4'hC}, '{5'h04, 0, 4'h2}, '{5'h01, 20, 4'hD}};
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      foreach (rows[i]) begin
         tick(20 * MSC);
         pulse(rows[i].req);
         tick(3);
         while (busy !== 1'h0) tick(1);
         tick(rows[i].ms * MSC);
         chk({en, rail, safe, awake}, rows[i].exp);
      end
      // cpu reset passes through; a request while busy is dropped
      pulse(5'h10);
      tick(4);
      chk({1'h0, brst_n, crst_n, cpu_in}, 4'h1);
      pulse(5'h08);
      while (busy !== 1'h0) tick(1);
      tick(2);
      chk({2'h0, line_n, busy}, 4'h2);
      // shutdown cuts the rail and host keeps the line high
      tick(20 * MSC);
      pulse(5'h02);
      tick(3);
      chk({en, rail, line_n, busy}, 4'h3);
      tick(5 * MSC);
      chk({en, rail, line_n, busy}, 4'h3);
      // second reset mid-run: outputs at rest, then the radio restarts
      @(posedge mclk);
      rst <= 1'h1;
      tick(1);
      chk({en, rr, awake, rail}, 4'h4);
      @(posedge mclk);
      rst <= 1'h0;
      tick(2);
      chk({en, rr, awake, busy}, 4'hC);
      tick(11 * MSC);
      chk({en, rr, awake, rail}, 4'hB);
      report_and_stop();
   end
endmodule // tb_radio_power_reset_supervisor
